// file: bench/sbrg_peer.sv
module sbrg_peer (
   input wire logic clock_i,
   output logic rx_o,
   output logic ext_clk_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Line idles high, clock stands low between bursts
   initial begin
      rx_o = 1'b1;
      ext_clk_o = 1'b0;
   end

   task automatic set_rx(input logic v);
      @(posedge clock_i);
      rx_o <= v;
   endtask

   // Half period in system cycles sets a prompt or a slow far side
   task automatic clk_burst(input int pulses, input int half);
      repeat (pulses) begin
         repeat (half) @(posedge clock_i);
         ext_clk_o <= 1'b1;
         repeat (half) @(posedge clock_i);
         ext_clk_o <= 1'b0;
      end
   endtask
endmodule // sbrg_peer

// file: bench/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import sbrg_pkg::*;

   logic clock_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hready, hresp, tick, rx_level, mclk, rx, ext_clk;
   int error_cnt = 0;
   int comparisons = 0;
   int tick_cnt = 0;
   int mclk_cnt = 0;

   sbrg_top sbrg_top_i (.clock_i(clock_i), .rst_b_i(rst_b_i), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
      .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp),
      .hrdata_o(hrdata), .rx_i(rx), .ext_clk_i(ext_clk), .rate_tick_o(tick),
      .rx_level_o(rx_level), .master_clk_o(mclk));
   sbrg_peer sbrg_peer_i (.clock_i(clock_i), .rx_o(rx), .ext_clk_o(ext_clk));

   initial forever #20 clock_i = ~clock_i;

   // Counted mid-cycle so a snapshot taken at a rising edge never races it
   always @(negedge clock_i) begin
      if (tick === 1'b1) tick_cnt++;
      if (mclk === 1'b1) mclk_cnt++;
   end

   task automatic wrap_up();
      if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_cnt(input string what, input int exp, input int got);
      comparisons++;
      if (got != exp) begin
         error_cnt++;
         $display("BAD %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= SBRG_HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge clock_i); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clock_i); while (hready !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] unused;
      bus(a, 1'b1, {24'h0, d}, unused);
   endtask

   task automatic wait_tick(output int n);
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (tick !== 1'b1 && n < 20000);
   endtask

   function automatic int exp_period(bit s, bit h, bit w, int hi, int lo);
      int k;
      k = s ? 4 : (w ? (h ? 4 : 16) : (h ? 16 : 64));
      return k * ((w ? hi * 256 : 0) + lo + 1);
   endfunction

   initial begin
      #1000000;
      error_cnt++;
      wrap_up();
   end

   initial begin
      logic [7:0] offs[6];
      logic [7:0] rst_v[6];
      logic [7:0] wr_v[6];
      logic [2:0] modes[7];
      logic [31:0] d;
      int n, p, lo, c, c2, low_seen;
      offs = '{SBRG_OFF_TXCTL, SBRG_OFF_RXCTL, SBRG_OFF_RATE, SBRG_OFF_DIVHI,
               SBRG_OFF_DIVLO, 8'h18};
      rst_v = '{SBRG_TXCTL_RST | SBRG_TXCTL_RO1, SBRG_RXCTL_RST,
                SBRG_RATE_RST | SBRG_RATE_RO1, SBRG_DIV_RST, SBRG_DIV_RST, 8'h00};
      wr_v = '{SBRG_TXCTL_WMASK | SBRG_TXCTL_RO1, SBRG_RXCTL_WMASK,
               SBRG_RATE_WMASK | SBRG_RATE_RO1, 8'hff, 8'hff, 8'h00};
      modes = '{3'b000, 3'b010, 3'b001, 3'b011, 3'b100, 3'b110, 3'b111};
      void'($urandom(4));
      repeat (5) @(posedge clock_i);
      rst_b_i <= 1'b1;
      @(posedge clock_i);
      foreach (offs[i]) begin
         bus(offs[i], 1'b0, 32'h0, d);
         chk("reset value", {24'h0, rst_v[i]}, d);
         wr(offs[i], 8'hff);
         bus(offs[i], 1'b0, 32'h0, d);
         chk("written value", {24'h0, wr_v[i]}, d);
      end
      // Mode bits {sync, high speed, wide}; high byte set so narrow mode must ignore it
      foreach (modes[i]) begin
         lo = $urandom_range(3, 0);
         p = exp_period(modes[i][2], modes[i][1], modes[i][0], 1, lo);
         wr(SBRG_OFF_RXCTL, 8'h80);
         wr(SBRG_OFF_TXCTL, {1'b1, 2'b00, modes[i][2], 1'b0, modes[i][1], 2'b00});
         wr(SBRG_OFF_RATE, {4'h0, modes[i][0], 3'h0});
         wr(SBRG_OFF_DIVHI, 8'h01);
         wr(SBRG_OFF_DIVLO, lo[7:0]);
         wait_tick(n);
         // Restart at the data-phase edge, tick seen one edge after it is launched
         chk_cnt("first tick delay", p + 1, n);
         c = mclk_cnt;
         wait_tick(n);
         chk_cnt("tick period", p, n);
         @(posedge clock_i);
         chk_cnt("master clock pulses", 1, mclk_cnt - c);
      end
      wr(SBRG_OFF_DIVHI, 8'h00);
      wr(SBRG_OFF_RXCTL, 8'h00);
      c = tick_cnt;
      repeat (300) @(posedge clock_i);
      chk_cnt("ticks while disabled", 0, tick_cnt - c);
      // Slave: ticks follow the far side clock, prompt and slow
      wr(SBRG_OFF_TXCTL, 8'h10);
      wr(SBRG_OFF_RXCTL, 8'h80);
      for (int h = 3; h <= 20; h += 17) begin
         repeat (10) @(posedge clock_i);
         c = tick_cnt;
         c2 = mclk_cnt;
         sbrg_peer_i.clk_burst(5, h);
         repeat (10) @(posedge clock_i);
         chk_cnt("slave ticks", 5, tick_cnt - c);
         chk_cnt("slave master clock", 0, mclk_cnt - c2);
      end
      wr(SBRG_OFF_TXCTL, 8'h90);
      wr(SBRG_OFF_DIVLO, 8'h00);
      sbrg_peer_i.set_rx(1'b0);
      repeat (20) @(posedge clock_i);
      chk("rx level low", 32'h0, {31'h0, rx_level});
      sbrg_peer_i.set_rx(1'b1);
      repeat (20) @(posedge clock_i);
      chk("rx level high", 32'h1, {31'h0, rx_level});
      // One-cycle glitch hits at most one of three samples
      sbrg_peer_i.set_rx(1'b0);
      sbrg_peer_i.set_rx(1'b1);
      low_seen = 0;
      repeat (20) begin
         @(posedge clock_i);
         if (rx_level !== 1'b1) low_seen++;
      end
      chk_cnt("glitch filtered", 0, low_seen);
      wrap_up();
   end
endmodule // tb

// file: rtl/sbrg_major.sv
module sbrg_major
   import sbrg_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic clear_i,
   input wire logic sample_i,
   input wire logic bit_i,
   output logic level_o
);
   logic [2:0] smp_q;
   logic [2:0] smp_d;

   assign smp_d = {smp_q[1:0], bit_i};

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         smp_q <= 3'h7;
         level_o <= 1'b1;
      end else if (clear_i) begin
         // Idle line is high
         smp_q <= 3'h7;
         level_o <= 1'b1;
      end else if (sample_i) begin
         smp_q <= smp_d;
         level_o <= (smp_d[0] & smp_d[1]) | (smp_d[0] & smp_d[2]) | (smp_d[1] & smp_d[2]);
      end
   end

   property p_majority;
      @(posedge clock_i) disable iff (!rst_b_i)
      (sample_i && !clear_i) |=> (level_o == ((smp_q[0] + smp_q[1] + smp_q[2]) >= 2'd2));
   endproperty
   a_majority: assert property (p_majority) else $error("majority vote wrong");
endmodule // sbrg_major

// file: rtl/sbrg_top.sv
//
// Function
// - Divider counts 8 bits after reset, 16 bits only while wide select set; in slave mode it wraps and counts 16 bits.
// - Divisor pair sets period of free-running timer whose terminal event ticks.
// - Async uses high-speed and wide selects; sync ignores high-speed select.
// - Async, 8-bit, low speed: rate is clock over 64 times divisor plus one.
// - Async, 16-bit, low speed: rate is clock over 16 times divisor plus one.
// - Sync master: rate is clock over 4 times divisor plus one.
// - Rate formulas apply to master only; slave takes its bit clock from outside.
// - Writing either divisor byte restarts the divider at once.
// - Divisor is high byte above low byte.
// - Receive level decided by majority of three samples.
// - With wide select clear, only the low divisor byte is used.
// - Port enable clear holds the divider in reset.
//
// Decided for this implementation: the placing of the registers and register access over AHB-Lite.
module sbrg_top
   import sbrg_pkg::*;
#(
   parameter int DIV_W = 16
) (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic hsel_i,
   input wire logic [7:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [31:0] hrdata_o,
   input wire logic rx_i,
   input wire logic ext_clk_i,
   output logic rate_tick_o,
   output logic rx_level_o,
   output logic master_clk_o
);
   if (DIV_W != 16) begin : g_chk
      $error("sbrg_top: divisor is a two-byte pair, DIV_W must be 16");
   end

   // Bus slave: zero wait states, always OKAY
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   logic [7:0] txctl_q;
   logic [7:0] rxctl_q;
   logic [7:0] rate_q;
   logic [7:0] divhi_q;
   logic [7:0] divlo_q;
   logic [31:0] rdata_d;
   logic addr_ph;
   logic div_wr;
   sbrg_cfg_t cfg;

   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign addr_ph = hsel_i && hready_i && (htrans_i == SBRG_HTRANS_NONSEQ || htrans_i[1]);

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else begin
         wr_pend_q <= addr_ph && hwrite_i;
         wr_addr_q <= haddr_i;
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         txctl_q <= SBRG_TXCTL_RST;
         rxctl_q <= SBRG_RXCTL_RST;
         rate_q <= SBRG_RATE_RST;
         divhi_q <= SBRG_DIV_RST;
         divlo_q <= SBRG_DIV_RST;
      end else if (wr_pend_q) begin
         case (wr_addr_q)
            SBRG_OFF_TXCTL: txctl_q <= hwdata_i[7:0] & SBRG_TXCTL_WMASK;
            SBRG_OFF_RXCTL: rxctl_q <= hwdata_i[7:0] & SBRG_RXCTL_WMASK;
            SBRG_OFF_RATE: rate_q <= hwdata_i[7:0] & SBRG_RATE_WMASK;
            SBRG_OFF_DIVHI: divhi_q <= hwdata_i[7:0];
            SBRG_OFF_DIVLO: divlo_q <= hwdata_i[7:0];
            default: ;
         endcase
      end
   end

   assign div_wr = wr_pend_q && (wr_addr_q == SBRG_OFF_DIVHI || wr_addr_q == SBRG_OFF_DIVLO);

   assign cfg.serial_port_enable = rxctl_q[SBRG_RX_SERIAL_PORT_ENABLE];
   assign cfg.sync = txctl_q[SBRG_TX_SYNC];
   assign cfg.clk_src = txctl_q[SBRG_TX_CLKSRC];
   assign cfg.hi_spd = txctl_q[SBRG_TX_HISPD];
   assign cfg.wide = rate_q[SBRG_RC_WIDE];

   // Divisor in effect, and the one about to be written for the restart
   logic [DIV_W-1:0] div_eff;
   logic [DIV_W-1:0] div_new;
   logic [7:0] hi_new;
   logic [7:0] lo_new;

   always_comb begin
      hi_new = divhi_q;
      lo_new = divlo_q;
      if (wr_pend_q && wr_addr_q == SBRG_OFF_DIVHI) begin
         hi_new = hwdata_i[7:0];
      end
      if (wr_pend_q && wr_addr_q == SBRG_OFF_DIVLO) begin
         lo_new = hwdata_i[7:0];
      end
   end

   assign div_eff = cfg.wide ? {divhi_q, divlo_q} : {8'h00, divlo_q};
   assign div_new = cfg.wide ? {hi_new, lo_new} : {8'h00, lo_new};

   // Prescale factor per mode
   logic [6:0] pre_len;

   always_comb begin
      if (cfg.sync) begin
         pre_len = SBRG_PRE_4;
      end else if (cfg.wide && cfg.hi_spd) begin
         pre_len = SBRG_PRE_4;
      end else if (cfg.wide || cfg.hi_spd) begin
         pre_len = SBRG_PRE_16;
      end else begin
         pre_len = SBRG_PRE_64;
      end
   end

   logic master;
   logic [6:0] pre_q;
   logic pre_en;
   logic [DIV_W-1:0] cnt_q;
   logic div_tick;
   logic narrow_wr;

   // Slave mode lets the divider keep counting and wrap, but masks div_tick
   assign master = !cfg.sync || cfg.clk_src;
   assign pre_en = (pre_q == pre_len - 7'h01);
   assign narrow_wr = wr_pend_q && (wr_addr_q == SBRG_OFF_RATE) && !hwdata_i[SBRG_RC_WIDE];

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pre_q <= 7'h00;
      end else if (!cfg.serial_port_enable || div_wr || pre_en || pre_q >= pre_len) begin
         // Mode change can leave pre_q beyond the new length
         pre_q <= 7'h00;
      end else begin
         pre_q <= pre_q + 7'h01;
      end
   end

   assign div_tick = cfg.serial_port_enable && master && pre_en && (cnt_q == '0);

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_q <= '0;
      end else if (!cfg.serial_port_enable) begin
         cnt_q <= '0;
      end else if (div_wr) begin
         cnt_q <= div_new;
      end else if (div_tick) begin
         cnt_q <= div_eff;
      end else if (pre_en) begin
         cnt_q <= narrow_wr ? {8'h00, cnt_q[7:0] - 8'h01} : cnt_q - 1'b1;
      end else if (narrow_wr) begin
         // Leftover wide count would stretch the first narrow period
         cnt_q <= {8'h00, cnt_q[7:0]};
      end
   end

   // Pin inputs: two flops before any logic
   logic [1:0] rx_sync_q;
   logic [2:0] ck_sync_q;
   logic ext_edge;

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rx_sync_q <= 2'h3;
         ck_sync_q <= 3'h0;
      end else begin
         rx_sync_q <= {rx_sync_q[0], rx_i};
         ck_sync_q <= {ck_sync_q[1:0], ext_clk_i};
      end
   end

   assign ext_edge = ck_sync_q[1] && !ck_sync_q[2];

   logic tick_q;
   logic mclk_q;

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tick_q <= 1'b0;
         mclk_q <= 1'b0;
      end else if (!cfg.serial_port_enable) begin
         tick_q <= 1'b0;
         mclk_q <= 1'b0;
      end else begin
         tick_q <= master ? div_tick : ext_edge;
         mclk_q <= master ? div_tick : 1'b0;
      end
   end

   assign rate_tick_o = tick_q;
   assign master_clk_o = mclk_q;

   sbrg_major u_major (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .clear_i(!cfg.serial_port_enable),
      .sample_i(pre_en),
      .bit_i(rx_sync_q[1]),
      .level_o(rx_level_o)
   );

   // Read data registered in the address phase
   always_comb begin
      rdata_d = 32'h0000_0000;
      case (haddr_i)
         SBRG_OFF_TXCTL: rdata_d[7:0] = txctl_q | SBRG_TXCTL_RO1;
         SBRG_OFF_RXCTL: rdata_d[7:0] = rxctl_q;
         SBRG_OFF_RATE: rdata_d[7:0] = rate_q | SBRG_RATE_RO1;
         SBRG_OFF_DIVHI: rdata_d[7:0] = divhi_q;
         SBRG_OFF_DIVLO: rdata_d[7:0] = divlo_q;
         SBRG_OFF_STAT: rdata_d = {7'h00, rx_level_o, 1'b0, pre_q, cnt_q};
         default: rdata_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hrdata_o <= 32'h0000_0000;
      end else if (addr_ph && !hwrite_i) begin
         hrdata_o <= rdata_d;
      end
   end

   // Helper logic for period checks
   logic [19:0] per_q;
   logic stable_q;
   logic [31:0] exp_per;

   assign exp_per = {25'h0, pre_len} * ({16'h0, div_eff} + 32'h1);

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         per_q <= 20'h0;
         stable_q <= 1'b0;
      end else begin
         per_q <= div_tick ? 20'h0 : per_q + 20'h1;
         if (wr_pend_q || !cfg.serial_port_enable) begin
            stable_q <= 1'b0;
         end else if (div_tick) begin
            stable_q <= 1'b1;
         end
      end
   end

   property p_rate_low8;
      @(posedge clock_i) disable iff (!rst_b_i)
      (div_tick && stable_q && !cfg.sync && !cfg.wide && !cfg.hi_spd)
         |-> ({12'h0, per_q} + 32'h1 == 32'd64 * ({16'h0, div_eff} + 32'h1));
   endproperty
   a_rate_low8: assert property (p_rate_low8) else $error("8-bit low rate wrong");

   property p_rate_low16;
      @(posedge clock_i) disable iff (!rst_b_i)
      (div_tick && stable_q && !cfg.sync && cfg.wide && !cfg.hi_spd)
         |-> ({12'h0, per_q} + 32'h1 == 32'd16 * ({16'h0, divhi_q, divlo_q} + 32'h1));
   endproperty
   a_rate_low16: assert property (p_rate_low16) else $error("16-bit low rate wrong");

   property p_rate_sync;
      @(posedge clock_i) disable iff (!rst_b_i)
      (div_tick && stable_q && cfg.sync)
         |-> ({12'h0, per_q} + 32'h1 == 32'd4 * ({16'h0, div_eff} + 32'h1));
   endproperty
   a_rate_sync: assert property (p_rate_sync) else $error("sync master rate wrong");

   property p_rate_hi;
      @(posedge clock_i) disable iff (!rst_b_i)
      (div_tick && stable_q && !cfg.sync && cfg.hi_spd)
         |-> ({12'h0, per_q} + 32'h1 == (cfg.wide ? 32'd4 : 32'd16) * ({16'h0, div_eff} + 32'h1));
   endproperty
   a_rate_hi: assert property (p_rate_hi) else $error("high speed rate wrong");

   property p_period;
      @(posedge clock_i) disable iff (!rst_b_i)
      (div_tick && stable_q) |-> ({12'h0, per_q} + 32'h1 == exp_per);
   endproperty
   a_period: assert property (p_period) else $error("tick period wrong");

   property p_sync_ignores_hs;
      @(posedge clock_i) disable iff (!rst_b_i)
      cfg.sync |-> (pre_len == 7'd4);
   endproperty
   a_sync_ignores_hs: assert property (p_sync_ignores_hs) else $error("sync uses high speed");

   property p_narrow;
      @(posedge clock_i) disable iff (!rst_b_i)
      (!cfg.wide && cfg.serial_port_enable && !div_wr) |-> (cnt_q[15:8] == 8'h00);
   endproperty
   a_narrow: assert property (p_narrow) else $error("high byte used while narrow");

   property p_wide;
      @(posedge clock_i) disable iff (!rst_b_i)
      cfg.wide |-> (div_eff == {divhi_q, divlo_q});
   endproperty
   a_wide: assert property (p_wide) else $error("divisor concatenation wrong");

   property p_restart;
      @(posedge clock_i) disable iff (!rst_b_i)
      (div_wr && cfg.serial_port_enable) |=> (pre_q == 7'h00 && cnt_q == div_eff);
   endproperty
   a_restart: assert property (p_restart) else $error("divisor write did not restart");

   property p_reload;
      @(posedge clock_i) disable iff (!rst_b_i)
      (div_tick && !div_wr) |=> (cnt_q == $past(div_eff) && !div_tick);
   endproperty
   a_reload: assert property (p_reload) else $error("no reload after tick");

   property p_hold;
      @(posedge clock_i) disable iff (!rst_b_i)
      !cfg.serial_port_enable |=> (cnt_q == '0 && pre_q == 7'h00 && !rate_tick_o);
   endproperty
   a_hold: assert property (p_hold) else $error("disabled port not held");

   property p_slave;
      @(posedge clock_i) disable iff (!rst_b_i)
      (cfg.serial_port_enable && !master) |=> (rate_tick_o == $past(ext_edge) && !master_clk_o);
   endproperty
   a_slave: assert property (p_slave) else $error("slave tick not from pin");

   c_tick_low8: cover property (@(posedge clock_i) disable iff (!rst_b_i)
      div_tick && stable_q && !cfg.sync && !cfg.wide);
   c_tick_sync: cover property (@(posedge clock_i) disable iff (!rst_b_i)
      div_tick && stable_q && cfg.sync);
   c_restart: cover property (@(posedge clock_i) disable iff (!rst_b_i)
      div_wr && cfg.serial_port_enable ##1 cnt_q != '0);
   c_slave: cover property (@(posedge clock_i) disable iff (!rst_b_i)
      rate_tick_o && !master);
endmodule // sbrg_top

// file: shared/sbrg_pkg.sv
package sbrg_pkg;
   // Byte offsets of the register words on the AHB-Lite bus
   localparam logic [7:0] SBRG_OFF_TXCTL = 8'h00;
   localparam logic [7:0] SBRG_OFF_RXCTL = 8'h04;
   localparam logic [7:0] SBRG_OFF_RATE = 8'h08;
   localparam logic [7:0] SBRG_OFF_DIVHI = 8'h0c;
   localparam logic [7:0] SBRG_OFF_DIVLO = 8'h10;
   localparam logic [7:0] SBRG_OFF_STAT = 8'h14;

   // Field positions
   localparam int SBRG_TX_CLKSRC = 7;
   localparam int SBRG_TX_SYNC = 4;
   localparam int SBRG_TX_HISPD = 2;
   localparam int SBRG_RX_SERIAL_PORT_ENABLE = 7;
   localparam int SBRG_RC_WIDE = 3;

   // Values after reset, writable masks and read-only ones
   localparam logic [7:0] SBRG_TXCTL_RST = 8'h00;
   localparam logic [7:0] SBRG_RXCTL_RST = 8'h00;
   localparam logic [7:0] SBRG_RATE_RST = 8'h00;
   localparam logic [7:0] SBRG_DIV_RST = 8'h00;
   localparam logic [7:0] SBRG_TXCTL_WMASK = 8'hfd;
   localparam logic [7:0] SBRG_RXCTL_WMASK = 8'hf8;
   localparam logic [7:0] SBRG_RATE_WMASK = 8'h9b;
   localparam logic [7:0] SBRG_TXCTL_RO1 = 8'h02;
   localparam logic [7:0] SBRG_RATE_RO1 = 8'h40;

   // Prescale factors, in clock cycles per divider step
   localparam logic [6:0] SBRG_PRE_64 = 7'h40;
   localparam logic [6:0] SBRG_PRE_16 = 7'h10;
   localparam logic [6:0] SBRG_PRE_4 = 7'h04;

   localparam logic [1:0] SBRG_HTRANS_NONSEQ = 2'h2;

   typedef struct packed {
      logic serial_port_enable;
      logic sync;
      logic clk_src;
      logic hi_spd;
      logic wide;
   } sbrg_cfg_t;
endpackage : sbrg_pkg
